// [bench/cfg_tail_asserts.sv]
// checker: register, pin and decode relations at the bank ports
// assumes: bound to the bank top, one clock domain
`timescale 1ns/10ps
module cfg_tail_asserts (
   // clock, reset, register port
   input wire logic clk, rstn, reg_wr, reg_rd, reg_hit,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   // limiter query
   input wire logic [6:0] limit_code,
   input wire logic limit_speed_ten, limit_top_queue, limit_active,
   input wire logic [16:0] limit_rate_kbps,
   // config pins
   input wire logic port_three_half_duplex, port_three_flow_ctrl,
   input wire logic third_mac_role_mac, port_four_tx_clk_invert
);
   logic [8:0] pv;
   logic [1:0] st;
   logic steady;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // decode judged only once the query has outlived its two-stage latency
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pv <= '0;
         st <= '0;
      end else begin
         pv <= {limit_code, limit_speed_ten, limit_top_queue};
         st <= (pv != {limit_code, limit_speed_ten, limit_top_queue}) ? 2'd0 :
            (st == 2'd3) ? st : st + 2'd1;
      end
   end
   // st lags the query by a cycle, so a fresh change must also be caught through pv
   assign steady = st != 2'd0 && pv == {limit_code, limit_speed_ten, limit_top_queue};
   a_half_dup: assert property (reg_wr && reg_addr == 8'hcf |->
      ##2 port_three_half_duplex == $past(reg_wdata[7], 2)) else $error("duplex pin wrong");
   a_flow_pin: assert property (reg_wr && reg_addr == 8'hcf |->
      ##2 port_three_flow_ctrl == $past(reg_wdata[6], 2)) else $error("flow pin wrong");
   a_mac_role: assert property (reg_wr && reg_addr == 8'hdf |->
      ##2 third_mac_role_mac == $past(reg_wdata[6], 2)) else $error("role pin wrong");
   a_clk_inv: assert property (reg_wr && reg_addr == 8'hff |->
      ##2 port_four_tx_clk_invert == $past(reg_wdata[6], 2)) else $error("invert pin wrong");
   a_test_ro: assert property (reg_rd && reg_addr == 8'hbf |=>
      reg_hit && reg_rdata == 8'h80) else $error("test register read wrong");
   a_rsvd_one: assert property (reg_rd && reg_addr == 8'hcf |=>
      reg_rdata[4:0] == 5'h15) else $error("reserved field read wrong");
   a_full_rate: assert property (steady && limit_code == 7'd0 && limit_top_queue &&
      !limit_speed_ten |-> limit_rate_kbps == 17'd100000 && !limit_active) else $error("full rate");
   a_sub_rate: assert property (steady && limit_top_queue &&
      limit_code inside {[101:115]} |-> limit_rate_kbps == (17'(limit_code) - 17'd100) * 17'd64)
      else $error("sub rate wrong");
   cover property (reg_wr && reg_addr == 8'hff);
   cover property (steady && limit_code == 7'd115);
   cover property (reg_rd && reg_addr == 8'h00 ##1 !reg_hit);
endmodule : cfg_tail_asserts
bind rate_code_and_port_iface_cfg cfg_tail_asserts cfg_tail_asserts_i (.*);

// [bench/mgmt_host.sv]
// partner: management host making single-byte register cycles
// assumes: bank samples strobes on rising clk
`timescale 1ns/10ps
module mgmt_host (
   // clock
   input wire logic clk,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // released address and data lines show inverted values so stale data never looks valid; strobes drop to zero
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : xfer
endmodule : mgmt_host

// [bench/tb.sv]
// testbench: register map, pins and limiter decode of the bank tail
// assumes: host model drives register port; limiter inputs driven here
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0, rstn = 1'b0, lq = 1'b0, top = 1'b1, spd = 1'b0, rd_d = 1'b0;
   logic reg_wr, reg_rd, reg_hit, act, undef, hd, fc, sp, role, inv;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [6:0] code = 7'h00;
   logic [3:0] ratio = 4'h0;
   logic [16:0] kbps;
   logic [2:0] lp = 3'h0;
   logic [8:0] rq[$];
   logic [18:0] lqq[$];
   logic [7:0] ad [6] = '{8'hbf, 8'hcf, 8'hdf, 8'hef, 8'hff, 8'h00};
   logic [8:0] rv [6] = '{9'h180, 9'h115, 9'h12c, 9'h132, 9'h100, 9'h000};
   logic [8:0] rs [6] = '{9'h180, 9'h1f5, 9'h16c, 9'h132, 9'h140, 9'h000};
   int error_cnt = 0, n_compared = 0, seed = 48517, n;
   initial forever #2.5 clk = ~clk;
   mgmt_host mgmt_host_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));
   rate_code_and_port_iface_cfg rate_code_and_port_iface_cfg_i (.clk(clk), .rstn(rstn),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit), .limit_code(code), .limit_speed_ten(spd),
      .limit_ratio(ratio), .limit_top_queue(top), .limit_rate_kbps(kbps), .limit_active(act),
      .limit_code_undefined(undef), .port_three_half_duplex(hd), .port_three_flow_ctrl(fc),
      .port_three_speed_ten(sp), .third_mac_role_mac(role), .port_four_tx_clk_invert(inv));
   task automatic chk(input logic [18:0] got, input logic [18:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      rq.push_back(e);
      mgmt_host_i.xfer(1'b0, a, 8'h00);
   endtask : rd
   task automatic pins(input logic [4:0] e);
      chk({14'h0, hd, fc, sp, role, inv}, {14'h0, e});
   endtask : pins
   task automatic lim(input logic s, t, input logic [6:0] c, input logic [3:0] r,
      input logic [16:0] e, input logic a, input logic u = 1'b0);
      lqq.push_back({u, a, e});
      @(posedge clk);
      {spd, top, code, ratio, lq} <= {s, t, c, r, 1'b1};
      @(posedge clk);
      lq <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : lim
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      if (rd_d) chk({10'h0, reg_hit, reg_rdata}, {10'h0, rq.pop_front()});
      if (lp[2]) chk({undef, act, kbps}, lqq.pop_front());
      rd_d <= reg_rd;
      lp <= {lp[1:0], lq};
   end
   initial begin
      #20000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      foreach (ad[i]) rd(ad[i], rv[i]);
      pins(5'h00);
      foreach (ad[i]) mgmt_host_i.xfer(1'b1, ad[i], 8'hff);
      foreach (ad[i]) rd(ad[i], rs[i]);
      pins(5'h1f);
      mgmt_host_i.xfer(1'b1, 8'hcf, 8'h40);
      mgmt_host_i.xfer(1'b1, 8'hff, 8'h00);
      rd(8'hcf, 9'h155);
      pins(5'h0a);
      // let the pending read answer be compared before reset wipes it
      repeat (2) @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(8'hdf, 9'h12c);
      pins(5'h00);
      lim(1'b0, 1'b1, 7'd0, 4'h0, 17'd100000, 1'b0);
      lim(1'b0, 1'b1, 7'd100, 4'h0, 17'd100000, 1'b0);
      lim(1'b1, 1'b1, 7'd0, 4'h0, 17'd10000, 1'b0);
      lim(1'b1, 1'b1, 7'd10, 4'h0, 17'd10000, 1'b0);
      lim(1'b0, 1'b1, 7'd99, 4'h0, 17'd99000, 1'b1);
      lim(1'b1, 1'b1, 7'd9, 4'h0, 17'd9000, 1'b1);
      lim(1'b0, 1'b0, 7'd50, 4'h4, 17'd12500, 1'b1);
      lim(1'b0, 1'b1, 7'd116, 4'h0, 17'd100000, 1'b0, 1'b1);
      lim(1'b1, 1'b1, 7'd50, 4'h0, 17'd10000, 1'b0, 1'b1);
      for (n = 101; n <= 115; n++) lim(n[0], 1'b1, 7'(n), 4'h0, 17'((n - 100) * 64), 1'b1);
      repeat (10) begin
         n = 1 + $unsigned($random(seed)) % 99;
         lim(1'b0, 1'b1, 7'(n), 4'h0, 17'(n * 1000), 1'b1);
         n = 1 + $unsigned($random(seed)) % 9;
         lim(1'b1, 1'b1, 7'(n), 4'h0, 17'(n * 1000), 1'b1);
      end
      repeat (2) @(posedge clk);
      conclude();
   end
endmodule : tb

// [design/rate_cfg_pkg.sv]
// package: register map, field layout, rate-code constants for the config bank tail
// assumes: byte-wide register port, 8-bit addresses, single switch clock
package rate_cfg_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CODE_W = 7;
   localparam logic [ADDR_W-1:0] OFS_TEST_FIXED = 8'hbf;
   localparam logic [ADDR_W-1:0] OFS_P3_CTRL_ONE = 8'hcf;
   localparam logic [ADDR_W-1:0] OFS_P3_CTRL_TWO = 8'hdf;
   localparam logic [ADDR_W-1:0] OFS_TEST_THREE = 8'hef;
   localparam logic [ADDR_W-1:0] OFS_P4_CTRL = 8'hff;
   localparam logic [DATA_W-1:0] TEST_FIXED_VAL = 8'h80;
   localparam logic [DATA_W-1:0] TEST_THREE_VAL = 8'h32;
   localparam logic [4:0] P3_ONE_RSVD_VAL = 5'h15;
   localparam logic [5:0] P3_TWO_RSVD_VAL = 6'h2c;
   localparam logic [5:0] P4_RSVD_VAL = 6'h00;
   localparam int unsigned BIT_HALF_DUPLEX = 7;
   localparam int unsigned BIT_FLOW_CTRL = 6;
   localparam int unsigned BIT_SPEED_TEN = 5;
   localparam int unsigned BIT_MAC_ROLE = 6;
   localparam int unsigned BIT_CLK_INVERT = 6;
   localparam logic [CODE_W-1:0] CODE_FULL = 7'h00;
   localparam logic [CODE_W-1:0] CODE_FULL_100 = 7'h64;
   localparam logic [CODE_W-1:0] CODE_FULL_10 = 7'h0a;
   localparam logic [CODE_W-1:0] CODE_SUB_LO = 7'h65;
   localparam logic [CODE_W-1:0] CODE_SUB_HI = 7'h73;
   // limiter rate output unit: kilobits per second
   localparam int unsigned KBPS_W = 17;
   localparam logic [KBPS_W-1:0] KBPS_PER_MBIT = 17'h003e8;
   localparam logic [KBPS_W-1:0] KBPS_SUB_STEP = 17'h00040;
   localparam logic [KBPS_W-1:0] KBPS_100M = 17'h186a0;
   localparam logic [KBPS_W-1:0] KBPS_10M = 17'h02710;
   localparam int unsigned RATIO_W = 4;
   typedef enum logic [1:0] {RATE_FULL, RATE_LIMIT, RATE_UNDEF} rate_kind_t;
endpackage : rate_cfg_pkg

// [design/rate_code_and_port_iface_cfg.sv]
// config bank tail: test registers, port three media iface control,
// port four reduced iface clock phase, and limiter code decode.
// assumes: byte register port driven by the serial management slave on clk.
//
// Summary of operation
// - 100M mode: codes 1-99 limit to that many megabits per second.
// - 100M mode: code 0 or 100 means no limit; limiter codes reset to zero.
// - codes 101-115 give 64 to 960 kbps in 64 kbps steps.
// - 10M mode: codes 1-9 limit to that many megabits per second.
// - 10M mode: code 0 or 10 means full rate; zero is default.
// - top queue gets exact rate; lower queues scaled by port ratio.
// - test register at 0xbf is read-only and reads 0x80.
// - port three ctrl one bit 7: half duplex when set, reset clear.
// - port three ctrl one bit 6: flow control enable, reset off.
// - port three ctrl one bit 5: 10M speed when set, reset 100M.
// - port three ctrl two bit 6: MAC role when set, PHY at reset.
// - reserved fields read 0x15, 0x2c, 0x00; host leaves them unchanged.
// - last register bit 6 inverts port four tx reference clock phase.
`timescale 1ns/10ps
module rate_code_and_port_iface_cfg (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [rate_cfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [rate_cfg_pkg::DATA_W-1:0] reg_wdata,
   output logic [rate_cfg_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_hit,
   // limiter code query
   input wire logic [rate_cfg_pkg::CODE_W-1:0] limit_code,
   input wire logic limit_speed_ten,
   input wire logic [rate_cfg_pkg::RATIO_W-1:0] limit_ratio,
   input wire logic limit_top_queue,
   output logic [rate_cfg_pkg::KBPS_W-1:0] limit_rate_kbps,
   output logic limit_active,
   output logic limit_code_undefined,
   // port three media iface
   output logic port_three_half_duplex,
   output logic port_three_flow_ctrl,
   output logic port_three_speed_ten,
   output logic third_mac_role_mac,
   // port four reduced iface
   output logic port_four_tx_clk_invert
);
   import rate_cfg_pkg::*;

   rate_decode_if dif ();

   logic half_duplex;
   logic flow_ctrl;
   logic speed_ten;
   logic mac_role;
   logic clk_invert;
   logic [DATA_W-1:0] next_rdata;
   logic next_hit;

   assign dif.code = limit_code;
   assign dif.speed_ten = limit_speed_ten;
   assign dif.ratio = limit_ratio;
   assign dif.top_queue = limit_top_queue;

   rate_code_decoder u_dec (
      .clk(clk),
      .rstn(rstn),
      .dec(dif)
   );

   // port three ctrl one: only the top three bits are writable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         half_duplex <= 1'b0;
         flow_ctrl <= 1'b0;
         speed_ten <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_P3_CTRL_ONE) begin
         half_duplex <= reg_wdata[BIT_HALF_DUPLEX];
         flow_ctrl <= reg_wdata[BIT_FLOW_CTRL];
         speed_ten <= reg_wdata[BIT_SPEED_TEN];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mac_role <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_P3_CTRL_TWO) begin
         mac_role <= reg_wdata[BIT_MAC_ROLE];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_invert <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_P4_CTRL) begin
         clk_invert <= reg_wdata[BIT_CLK_INVERT];
      end
   end

   // read mux; reserved fields are constants so writes cannot disturb them
   always_comb begin
      next_rdata = '0;
      next_hit = 1'b1;
      unique case (reg_addr)
         OFS_TEST_FIXED: next_rdata = TEST_FIXED_VAL;
         OFS_P3_CTRL_ONE: next_rdata = {half_duplex, flow_ctrl, speed_ten,
            P3_ONE_RSVD_VAL};
         OFS_P3_CTRL_TWO: next_rdata = {1'b0, mac_role, P3_TWO_RSVD_VAL};
         OFS_TEST_THREE: next_rdata = TEST_THREE_VAL;
         OFS_P4_CTRL: next_rdata = {1'b0, clk_invert, P4_RSVD_VAL};
         default: next_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
         reg_hit <= 1'b0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
         reg_hit <= next_hit;
      end else begin
         reg_hit <= 1'b0;
      end
   end

   // outputs registered once more so each comes straight from a flop
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_three_half_duplex <= 1'b0;
         port_three_flow_ctrl <= 1'b0;
         port_three_speed_ten <= 1'b0;
         third_mac_role_mac <= 1'b0;
         port_four_tx_clk_invert <= 1'b0;
      end else begin
         port_three_half_duplex <= half_duplex;
         port_three_flow_ctrl <= flow_ctrl;
         port_three_speed_ten <= speed_ten;
         third_mac_role_mac <= mac_role;
         port_four_tx_clk_invert <= clk_invert;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         limit_rate_kbps <= KBPS_100M;
         limit_active <= 1'b0;
         limit_code_undefined <= 1'b0;
      end else begin
         limit_rate_kbps <= dif.rate_kbps;
         limit_active <= dif.limited;
         limit_code_undefined <= dif.undefined;
      end
   end
endmodule : rate_code_and_port_iface_cfg

// [design/rate_code_decoder.sv]
// rate-code decoder: turns a 7-bit limiter code into a kbps figure, registered
// assumes: code stable one cycle before use; clk 200 MHz
`timescale 1ns/10ps
module rate_code_decoder (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // decode link
   rate_decode_if.decoder dec
);
   import rate_cfg_pkg::*;

   function automatic rate_kind_t classify(input logic [CODE_W-1:0] c, input logic ten);
      rate_kind_t k;
      k = RATE_UNDEF;
      if (c == CODE_FULL) k = RATE_FULL;
      else if (!ten && c == CODE_FULL_100) k = RATE_FULL;
      else if (ten && c == CODE_FULL_10) k = RATE_FULL;
      else if (!ten && c < CODE_FULL_100) k = RATE_LIMIT;
      else if (ten && c < CODE_FULL_10) k = RATE_LIMIT;
      else if (c >= CODE_SUB_LO && c <= CODE_SUB_HI) k = RATE_LIMIT;
      return k;
   endfunction : classify

   function automatic logic [KBPS_W-1:0] code_kbps(input logic [CODE_W-1:0] c);
      logic [KBPS_W-1:0] r;
      if (c >= CODE_SUB_LO)
         r = KBPS_W'((c - CODE_SUB_LO + 7'h01) * KBPS_SUB_STEP);
      else
         r = KBPS_W'(c * KBPS_PER_MBIT);
      return r;
   endfunction : code_kbps

   rate_kind_t kind;
   logic [KBPS_W-1:0] exact;
   logic [KBPS_W-1:0] full;
   logic [KBPS_W-1:0] next_rate;

   always_comb begin
      kind = classify(dec.code, dec.speed_ten);
      full = dec.speed_ten ? KBPS_10M : KBPS_100M;
      exact = (kind == RATE_LIMIT) ? code_kbps(dec.code) : full;
      // lower queues get a share of the exact rate set by the port ratio
      if (dec.top_queue || dec.ratio == '0)
         next_rate = exact;
      else
         next_rate = exact / KBPS_W'(dec.ratio);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dec.rate_kbps <= KBPS_100M;
         dec.limited <= 1'b0;
         dec.undefined <= 1'b0;
      end else begin
         dec.rate_kbps <= next_rate;
         dec.limited <= (kind == RATE_LIMIT);
         // undefined codes still pass at full rate; host is not to write them
         dec.undefined <= (kind == RATE_UNDEF);
      end
   end
endmodule : rate_code_decoder

// [design/rate_decode_if.sv]
// interface: code in, decoded limit out, between bank and rate decoder
// assumes: same clock as the bank
`timescale 1ns/10ps
interface rate_decode_if;
   import rate_cfg_pkg::*;
   logic [CODE_W-1:0] code;
   logic speed_ten;
   logic [RATIO_W-1:0] ratio;
   logic top_queue;
   logic [KBPS_W-1:0] rate_kbps;
   logic limited;
   logic undefined;
   modport bank (output code, output speed_ten, output ratio, output top_queue,
      input rate_kbps, input limited, input undefined);
   modport decoder (input code, input speed_ten, input ratio, input top_queue,
      output rate_kbps, output limited, output undefined);
endinterface : rate_decode_if
